// *** ccp_pkg.sv ***
// package of register map, mode codes and field positions for the capture/compare/pwm unit
package ccp_pkg;
  localparam logic [7:0] UNIT_ONE_MODE_CONTROL_OFS = 8'h17;
  localparam logic [7:0] UNIT_TWO_MODE_CONTROL_OFS = 8'h1D;
  localparam logic [7:0] TIMER_COUNT_OFS = 8'h20;
  localparam logic [7:0] TIMER_CONTROL_OFS = 8'h21;
  localparam logic [7:0] FLAG_OFS = 8'h22;
  localparam logic [7:0] ENABLE_OFS = 8'h23;
  localparam logic [7:0] UNIT_ONE_VALUE_OFS = 8'h24;
  localparam logic [7:0] UNIT_TWO_VALUE_OFS = 8'h25;
  localparam logic [7:0] UNIT_ONE_DUTY_HIGH_OFS = 8'h26;
  localparam logic [7:0] UNIT_TWO_DUTY_HIGH_OFS = 8'h27;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h3F;
  localparam int DUTY_LO_POS = 4;
  localparam int UNIT_ONE_FLAG_BIT = 2;
  localparam int UNIT_TWO_FLAG_BIT = 0;
  localparam int CONV_EN_BIT = 1;
  localparam int TMR_RUN_BIT = 0;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
  localparam logic [3:0] PRESCALE_FOUR = 4'h3;
  localparam logic [3:0] PRESCALE_SIXTEEN = 4'hF;
endpackage

// *** ccp_unit.sv ***
// one capture/compare/pwm channel
`timescale 1ns/100ps
module ccp_unit
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic [7:0] ctrl,
  input wire logic [7:0] dutyHigh,
  input wire logic [15:0] timerCount,
  input wire logic [15:0] valueWr,
  input wire logic valueWe,
  // pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  // status
  output logic [15:0] value,
  output logic unitEvent,
  output logic special
);
  logic pinPrev_r;
  logic [3:0] preCnt_r;
  logic [3:0] modePrev_r;
  logic [9:0] pwmCnt_r;
  logic [9:0] dutyLatch_r;
  logic [3:0] mode;
  logic isCap;
  logic isCmp;
  logic isPwm;
  logic rise;
  logic fall;
  logic preHit;
  logic capEv;
  logic match;
  logic [9:0] duty;
  assign mode = ctrl[3:0];
  assign isCap = mode[3:2] == 2'b01;
  assign isCmp = mode[3:2] == 2'b10;
  assign isPwm = mode[3:2] == 2'b11;
  // edge sensing ignores pin direction
  assign rise = pinIn & ~pinPrev_r;
  assign fall = ~pinIn & pinPrev_r;
  assign preHit = (mode == MODE_CAP_RISE4) ? (preCnt_r[1:0] == PRESCALE_FOUR[1:0]) :
                  (mode == MODE_CAP_RISE16) ? (preCnt_r == PRESCALE_SIXTEEN) : 1'b1;
  assign capEv = ((mode == MODE_CAP_FALL) & fall) |
                 ((mode == MODE_CAP_RISE) & rise) |
                 (((mode == MODE_CAP_RISE4) | (mode == MODE_CAP_RISE16)) & rise & preHit);
  assign match = isCmp & (timerCount == value);
  assign duty = {dutyHigh, ctrl[DUTY_LO_POS+1:DUTY_LO_POS]};
  assign pinOe = isCmp | isPwm;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinPrev_r <= 1'b0;
      preCnt_r <= 4'h0;
      modePrev_r <= MODE_OFF;
      pwmCnt_r <= 10'h000;
      dutyLatch_r <= 10'h000;
      value <= 16'h0000;
      pinOut <= 1'b0;
      unitEvent <= 1'b0;
      special <= 1'b0;
    end else begin
      pinPrev_r <= pinIn;
      modePrev_r <= mode;
      unitEvent <= capEv | match;
      // one trigger per match: the timer reset lands a cycle later
      special <= match & (mode == MODE_CMP_SPECIAL) & ~special;
      if (mode == MODE_OFF) begin
        preCnt_r <= 4'h0;
        pwmCnt_r <= 10'h000;
        pinOut <= 1'b0;
      end else if (mode != modePrev_r) begin
        preCnt_r <= 4'h0;
      end else if (isCap & rise) begin
        preCnt_r <= preCnt_r + 4'h1;
      end
      if (capEv) begin
        value <= timerCount;
      end else if (valueWe) begin
        value <= valueWr;
      end
      if (match & (mode == MODE_CMP_SET)) begin
        pinOut <= 1'b1;
      end else if (match & (mode == MODE_CMP_CLR)) begin
        pinOut <= 1'b0;
      end else if (isPwm) begin
        pwmCnt_r <= pwmCnt_r + 10'h001;
        if (pwmCnt_r == 10'h3FF) begin
          dutyLatch_r <= duty;
        end
        pinOut <= (pwmCnt_r < dutyLatch_r);
      end
    end
  end
endmodule

// *** ccp_top.sv ***
// wishbone register block holding two capture/compare/pwm units and a 16-bit timer
`timescale 1ns/100ps
module ccp_top
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // unit pins
  input wire logic unitPinOneIn,
  output logic unitPinOneOut,
  output logic unitPinOneOe,
  input wire logic unitPinTwoIn,
  output logic unitPinTwoOut,
  output logic unitPinTwoOe,
  // converter start
  output logic convStart
);
  logic [7:0] ctrlOne_r;
  logic [7:0] ctrlTwo_r;
  logic [7:0] dutyOne_r;
  logic [7:0] dutyTwo_r;
  logic [15:0] timer_r;
  logic [7:0] tmrCtrl_r;
  logic [7:0] flag_r;
  logic [7:0] enable_r;
  logic [15:0] valOne;
  logic [15:0] valTwo;
  logic evOne;
  logic evTwo;
  logic spOne;
  logic spTwo;
  logic outOne;
  logic outTwo;
  logic oeOne;
  logic oeTwo;
  logic [7:0] wordIdx;
  logic req;
  logic wr;
  logic mapped;
  logic [31:0] rdData;
  logic lane0;
  logic lane1;
  logic [7:0] flagWr;
  logic [15:0] valWr;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] ofs);
    hit = (idx == ofs);
  endfunction

  assign wordIdx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr = req & wb_we_i & mapped;
  assign lane0 = wb_sel_i[0];
  assign lane1 = wb_sel_i[1];
  assign mapped = hit(wordIdx, UNIT_ONE_MODE_CONTROL_OFS) | hit(wordIdx, UNIT_TWO_MODE_CONTROL_OFS) |
                  hit(wordIdx, TIMER_COUNT_OFS) | hit(wordIdx, TIMER_CONTROL_OFS) |
                  hit(wordIdx, FLAG_OFS) | hit(wordIdx, ENABLE_OFS) |
                  hit(wordIdx, UNIT_ONE_VALUE_OFS) | hit(wordIdx, UNIT_TWO_VALUE_OFS) |
                  hit(wordIdx, UNIT_ONE_DUTY_HIGH_OFS) | hit(wordIdx, UNIT_TWO_DUTY_HIGH_OFS);
  assign valWr = {lane1 ? wb_dat_i[15:8] : 8'h00, lane0 ? wb_dat_i[7:0] : 8'h00};

  always_comb begin
    if (hit(wordIdx, UNIT_ONE_MODE_CONTROL_OFS)) begin
      rdData = {24'h000000, ctrlOne_r & CTRL_IMPL_MASK};
    end else if (hit(wordIdx, UNIT_TWO_MODE_CONTROL_OFS)) begin
      rdData = {24'h000000, ctrlTwo_r & CTRL_IMPL_MASK};
    end else if (hit(wordIdx, TIMER_COUNT_OFS)) begin
      rdData = {16'h0000, timer_r};
    end else if (hit(wordIdx, TIMER_CONTROL_OFS)) begin
      rdData = {24'h000000, tmrCtrl_r};
    end else if (hit(wordIdx, FLAG_OFS)) begin
      rdData = {24'h000000, flag_r};
    end else if (hit(wordIdx, ENABLE_OFS)) begin
      rdData = {24'h000000, enable_r};
    end else if (hit(wordIdx, UNIT_ONE_VALUE_OFS)) begin
      rdData = {16'h0000, valOne};
    end else if (hit(wordIdx, UNIT_TWO_VALUE_OFS)) begin
      rdData = {16'h0000, valTwo};
    end else if (hit(wordIdx, UNIT_ONE_DUTY_HIGH_OFS)) begin
      rdData = {24'h000000, dutyOne_r};
    end else if (hit(wordIdx, UNIT_TWO_DUTY_HIGH_OFS)) begin
      rdData = {24'h000000, dutyTwo_r};
    end else begin
      rdData = 32'h00000000;
    end
  end

  // flag write: software value, then hardware events win
  always_comb begin
    flagWr = flag_r;
    if (wr & lane0 & hit(wordIdx, FLAG_OFS)) begin
      flagWr = wb_dat_i[7:0];
    end
    if (evOne) begin
      flagWr[UNIT_ONE_FLAG_BIT] = 1'b1;
    end
    if (evTwo) begin
      flagWr[UNIT_TWO_FLAG_BIT] = 1'b1;
    end
  end

  // bus answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= (req & mapped & ~wb_we_i) ? rdData : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrlOne_r <= CTRL_RESET;
      ctrlTwo_r <= CTRL_RESET;
      dutyOne_r <= 8'h00;
      dutyTwo_r <= 8'h00;
      tmrCtrl_r <= 8'h00;
      enable_r <= 8'h00;
      flag_r <= 8'h00;
    end else begin
      flag_r <= flagWr;
      if (wr & lane0) begin
        if (hit(wordIdx, UNIT_ONE_MODE_CONTROL_OFS)) begin
          ctrlOne_r <= wb_dat_i[7:0] & CTRL_IMPL_MASK;
        end
        if (hit(wordIdx, UNIT_TWO_MODE_CONTROL_OFS)) begin
          ctrlTwo_r <= wb_dat_i[7:0] & CTRL_IMPL_MASK;
        end
        if (hit(wordIdx, UNIT_ONE_DUTY_HIGH_OFS)) begin
          dutyOne_r <= wb_dat_i[7:0];
        end
        if (hit(wordIdx, UNIT_TWO_DUTY_HIGH_OFS)) begin
          dutyTwo_r <= wb_dat_i[7:0];
        end
        if (hit(wordIdx, TIMER_CONTROL_OFS)) begin
          tmrCtrl_r <= wb_dat_i[7:0];
        end
        if (hit(wordIdx, ENABLE_OFS)) begin
          enable_r <= wb_dat_i[7:0];
        end
      end
    end
  end

  // timer: special-event match resets, else counts when running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer_r <= 16'h0000;
      convStart <= 1'b0;
    end else begin
      convStart <= spTwo & tmrCtrl_r[CONV_EN_BIT];
      if (spOne | spTwo) begin
        timer_r <= 16'h0000;
      end else if (wr & hit(wordIdx, TIMER_COUNT_OFS)) begin
        timer_r <= valWr;
      end else if (tmrCtrl_r[TMR_RUN_BIT]) begin
        timer_r <= timer_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      unitPinOneOut <= 1'b0;
      unitPinOneOe <= 1'b0;
      unitPinTwoOut <= 1'b0;
      unitPinTwoOe <= 1'b0;
    end else begin
      unitPinOneOut <= outOne;
      unitPinOneOe <= oeOne;
      unitPinTwoOut <= outTwo;
      unitPinTwoOe <= oeTwo;
    end
  end

  ccp_unit unitOne (
    .clk(clk),
    .rstn(rstn),
    .ctrl(ctrlOne_r),
    .dutyHigh(dutyOne_r),
    .timerCount(timer_r),
    .valueWr(valWr),
    .valueWe(wr & hit(wordIdx, UNIT_ONE_VALUE_OFS)),
    .pinIn(unitPinOneIn),
    .pinOut(outOne),
    .pinOe(oeOne),
    .value(valOne),
    .unitEvent(evOne),
    .special(spOne)
  );

  ccp_unit unitTwo (
    .clk(clk),
    .rstn(rstn),
    .ctrl(ctrlTwo_r),
    .dutyHigh(dutyTwo_r),
    .timerCount(timer_r),
    .valueWr(valWr),
    .valueWe(wr & hit(wordIdx, UNIT_TWO_VALUE_OFS)),
    .pinIn(unitPinTwoIn),
    .pinOut(outTwo),
    .pinOe(oeTwo),
    .value(valTwo),
    .unitEvent(evTwo),
    .special(spTwo)
  );
endmodule

// *** ccp_top_chk.sv ***
// port assertions for the capture/compare/pwm register block
`timescale 1ns/100ps
module ccp_top_chk
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // pins
  input wire logic unitPinOneOut,
  input wire logic unitPinOneOe,
  input wire logic convStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic ctlRd = wb_ack_o && !wb_we_i && (wb_adr_i[9:2] == UNIT_ONE_MODE_CONTROL_OFS
    || wb_adr_i[9:2] == UNIT_TWO_MODE_CONTROL_OFS);
  wire logic offWr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == UNIT_ONE_MODE_CONTROL_OFS
    && wb_dat_i[3:0] == MODE_OFF;
  a_bus_answer: assert property (take |=> wb_ack_o || wb_err_o) else $error("no answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_err_alone: assert property (wb_err_o |-> !wb_ack_o && wb_dat_o == 32'h0) else $error("bad err");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  a_ctrl_top_zero: assert property (ctlRd |-> wb_dat_o[7:6] == 2'h0)
    else $error("control top bits set");
  a_off_quiet: assert property (offWr |-> ##[1:3] !(unitPinOneOe || unitPinOneOut))
    else $error("pin driven after off");
  a_conv_pulse: assert property (convStart |=> !convStart)
    else $error("conversion start too long");
  a_reset_quiet: assert property (!$past(rstn) |-> !wb_ack_o && !unitPinOneOe && !convStart)
    else $error("output active after reset");
  c_ctl_read: cover property (ctlRd);
  c_err: cover property (wb_err_o);
  c_conv: cover property (convStart);
endmodule
bind ccp_top ccp_top_chk chk_u(.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .unitPinOneOut(unitPinOneOut), .unitPinOneOe(unitPinOneOe),
  .convStart(convStart));

// *** ccp_pin_model.sv ***
// outside party on a unit pin: yields the wire while the unit drives it
`timescale 1ns/100ps
module ccp_pin_model (
  // unit side
  input wire logic pinOut,
  input wire logic pinOe,
  // bench side
  input wire logic extLvl,
  output logic pinIn
);
  // pin level is seen whatever its direction
  assign pinIn = pinOe ? pinOut : extLvl;
endmodule

// *** ccp_top_bench.sv ***
// self-checking bench for the capture/compare/pwm register block
`timescale 1ns/100ps
module ccp_top_bench;
  import ccp_pkg::*;
  logic clk, rstn, cyc, stb, we, ack, err, gotErr, o1, oe1, o2, oe2, conv, in1, in2, ext1, ext2, convSeen;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, rd;
  int miscompares = 0, checksDone = 0, cycles = 0;
  ccp_top dut_u(.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .unitPinOneIn(in1),
    .unitPinOneOut(o1), .unitPinOneOe(oe1), .unitPinTwoIn(in2), .unitPinTwoOut(o2), .unitPinTwoOe(oe2),
    .convStart(conv));
  ccp_pin_model pin1_u(.pinOut(o1), .pinOe(oe1), .extLvl(ext1), .pinIn(in1));
  ccp_pin_model pin2_u(.pinOut(o2), .pinOe(oe2), .extLvl(ext2), .pinIn(in2));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (conv === 1'h1) convSeen <= 1'h1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= 4'h3;
    adr <= {idx, 2'h0};
    datI <= d;
    do @(posedge clk); while (ack !== 1'h1 && err !== 1'h1);
    rd = datO;
    gotErr = err;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic pulse();
    ext1 <= 1'h1;
    repeat (3) @(posedge clk);
    ext1 <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs();
    bus(0, UNIT_ONE_MODE_CONTROL_OFS, 0);
    chk(rd, 32'h0);
    bus(1, UNIT_TWO_MODE_CONTROL_OFS, 32'hFF);
    bus(0, UNIT_TWO_MODE_CONTROL_OFS, 0);
    chk(rd, 32'h3F);
    bus(1, UNIT_TWO_MODE_CONTROL_OFS, 0);
    bus(0, 8'h05, 0);
    chk(gotErr, 1'h1);
    chk(rd, 32'h0);
    $display("register test done");
  endtask
  task automatic t_capture();
    int n;
    for (int i = 0; i < 4; i++) begin
      n = (i < 2) ? 1 : (i == 2) ? 4 : 16;
      bus(1, TIMER_CONTROL_OFS, 0);
      bus(1, TIMER_COUNT_OFS, 32'h1230 + i);
      bus(1, UNIT_ONE_MODE_CONTROL_OFS, 32'h4 + i);
      bus(1, FLAG_OFS, 0);
      repeat (n - 1) pulse();
      bus(0, FLAG_OFS, 0);
      chk(rd[UNIT_ONE_FLAG_BIT], 1'h0);
      pulse();
      bus(0, UNIT_ONE_VALUE_OFS, 0);
      chk(rd, 32'h1230 + i);
      bus(1, TIMER_COUNT_OFS, 32'hBEE0 + i);
      repeat (n) pulse();
      bus(0, UNIT_ONE_VALUE_OFS, 0);
      chk(rd, 32'hBEE0 + i);
      bus(0, FLAG_OFS, 0);
      chk(rd[UNIT_ONE_FLAG_BIT], 1'h1);
    end
    $display("capture test done");
  endtask
  task automatic t_compare();
    logic [3:0] ms[4] = '{4'h8, 4'h9, 4'hA, 4'hB};
    bus(1, UNIT_ONE_VALUE_OFS, 32'h77);
    for (int i = 0; i < 4; i++) begin
      bus(1, TIMER_COUNT_OFS, 0);
      bus(1, FLAG_OFS, 0);
      bus(1, UNIT_ONE_MODE_CONTROL_OFS, {28'h0, ms[i]});
      bus(0, FLAG_OFS, 0);
      chk(rd[UNIT_ONE_FLAG_BIT], 1'h0);
      bus(1, TIMER_COUNT_OFS, 32'h77);
      repeat (4) @(posedge clk);
      bus(0, FLAG_OFS, 0);
      chk(rd[UNIT_ONE_FLAG_BIT], 1'h1);
      if (i < 3) chk({oe1, o1}, {1'h1, i == 0});
    end
    bus(0, TIMER_COUNT_OFS, 0);
    chk(rd, 32'h0);
    bus(1, UNIT_ONE_MODE_CONTROL_OFS, 0);
    repeat (3) @(posedge clk);
    chk(oe1, 1'h0);
    bus(1, TIMER_COUNT_OFS, 32'h55);
    bus(1, UNIT_TWO_VALUE_OFS, 32'h55);
    bus(1, TIMER_CONTROL_OFS, 32'h2);
    convSeen <= 1'h0;
    bus(1, UNIT_TWO_MODE_CONTROL_OFS, 32'hB);
    repeat (6) @(posedge clk);
    chk(convSeen, 1'h1);
    chk({oe2, o2}, 2'h2);
    $display("compare test done");
  endtask
  task automatic t_pwm();
    int hi = 0;
    bus(1, UNIT_ONE_DUTY_HIGH_OFS, 32'h80);
    bus(1, UNIT_ONE_MODE_CONTROL_OFS, 32'h3C);
    repeat (2100) @(posedge clk);
    repeat (1024) begin
      @(posedge clk);
      if (o1 === 1'h1) hi++;
    end
    chk(hi, 32'h203);
    $display("pwm test done");
  endtask
  initial begin
    rstn = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 10'h0;
    sel = 4'h3;
    datI = 32'h0;
    ext1 = 1'h0;
    ext2 = 1'h0;
    convSeen = 1'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    t_regs();
    t_capture();
    t_compare();
    t_pwm();
    close_out();
  end
endmodule
